// ---- design/cc_attach_detect_debounce.sv ----
// Summary of operation
// - Attach declared only after stable connection for 2 to 15 ms.
// - Detach declared only after 10 to 20 ms of persistent open.
// - Sink accepts new current advertisement after it persists 10 to 20 ms.
// - Accessory mode entered after 50 ms to 200 ms of detection.
// - Recovery state held at least 25 ms before leaving.
// - Default-advertising source: powered below 0.20 V, sink below 1.60 V, else open.
// - Source thresholds: 0.40/1.60 V middle, 0.80/2.60 V high advertisement.
// - Decoding sink: default below 0.66 V, middle below 1.23 V, else high.
// - Non-decoding sink: powered below 0.2 V, source connected from 0.25 V.
// - Port state is four independent bits, sixteen combinations; data_capable stays at its reset 1, so only eight occur.
// - Power swap flips source/sink only; data swap flips host/device only.
// - Cable-power swap flips only the cable-power sourcing bit.
`timescale 1ns/100ps
`default_nettype none
module cc_attach_detect_debounce
    import cc_detect_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES  // Core clocks per debounce tick
)
(
    // Clock, reset, enable
    input  wire logic                      core_clk,
    input  wire logic                      srst,
    input  wire logic                      clk_en,
    // Comparator result and configuration
    input  wire logic [11:0]               cc_level_mv,
    input  wire logic                      source_mode,
    input  wire cc_detect_pkg::adv_t       own_adv,
    input  wire logic                      adv_decode_en,
    input  wire logic                      accessory_seen,
    input  wire cc_detect_pkg::timing_cfg_t timing_cfg,
    // Recovery and swaps
    input  wire logic                      recovery_req,
    input  wire cc_detect_pkg::swap_t      swap_done,
    // Status
    output logic                           attached,
    output logic                           accessory_mode,
    output logic                           recovery_state,
    output cc_detect_pkg::cc_class_t       cc_class,
    output cc_detect_pkg::adv_t            partner_adv,
    output cc_detect_pkg::port_state_t     port_state
);
    import cc_detect_pkg::*;

    typedef enum logic [2:0] {ST_UNATTACHED, ST_ATTACH_WAIT, ST_ATTACHED,
                              ST_ACC_WAIT, ST_ACCESSORY, ST_RECOVERY} fsm_t;
    fsm_t        state_reg,   state_next;
    logic [11:0] tmr_reg,     tmr_next;
    logic [11:0] open_tmr_reg, open_tmr_next;
    logic [11:0] adv_tmr_reg, adv_tmr_next;
    logic [13:0] pre_reg,     pre_next;
    logic        tick;
    cc_class_t   cls_raw, cls_reg, cls_next, stable_cls_reg, stable_cls_next;
    adv_t        adv_raw, adv_cand_reg, adv_cand_next, adv_reg, adv_next;
    port_state_t ps_reg,      ps_next;
    logic        connected;
    logic [11:0] att_tc, det_tc, acc_tc, rec_tc;
    assign tick = (pre_reg == 14'(TICK_DIV - 1));
    // Software-chosen counts are forced into the legal window
    assign att_tc = clamp_count(timing_cfg.attach_time, ATTACH_MIN_TK, ATTACH_MAX_TK);
    assign det_tc = clamp_count(timing_cfg.detach_time, DETACH_MIN_TK, DETACH_MAX_TK);
    assign acc_tc = clamp_count(timing_cfg.accessory_time, ACC_MIN_TK, ACC_MAX_TK);
    assign rec_tc = (timing_cfg.recovery_time < RECOVERY_MIN_TK) ? RECOVERY_MIN_TK
                                                                 : timing_cfg.recovery_time;

    // Level classification from role and advertisement
    always_comb begin
        logic [11:0] ra_th;
        logic [11:0] rd_th;
        ra_th = SRC_DEF_RA_MV;
        rd_th = SRC_DEF_RD_MV;
        unique case (own_adv)
            ADV_MIDDLE: begin
                ra_th = SRC_MID_RA_MV;
                rd_th = SRC_MID_RD_MV;
            end
            ADV_HIGH: begin
                ra_th = SRC_HI_RA_MV;
                rd_th = SRC_HI_RD_MV;
            end
            default: begin
                ra_th = SRC_DEF_RA_MV;
                rd_th = SRC_DEF_RD_MV;
            end
        endcase
        adv_raw = ADV_DEFAULT;
        if (source_mode) begin
            if (cc_level_mv < ra_th) begin
                cls_raw = CC_POWERED;
            end else if (cc_level_mv < rd_th) begin
                cls_raw = CC_SINK;
            end else begin
                cls_raw = CC_OPEN;
            end
        end else begin
            // The 0.2 to 0.25 V gap keeps the previous decision
            if (cc_level_mv < SNK_RA_MV) begin
                cls_raw = CC_POWERED;
            end else if (cc_level_mv >= SNK_CONNECT_MV) begin
                cls_raw = CC_SOURCE;
            end else begin
                cls_raw = cls_reg;
            end
            if (adv_decode_en) begin
                if (cc_level_mv < SNK_DEF_MV) begin
                    adv_raw = ADV_DEFAULT;
                end else if (cc_level_mv < SNK_MID_MV) begin
                    adv_raw = ADV_MIDDLE;
                end else begin
                    adv_raw = ADV_HIGH;
                end
            end
        end
    end

    assign connected = source_mode ? (stable_cls_reg == CC_SINK)
                                   : (stable_cls_reg == CC_SOURCE);
    // Debounce and sequencing
    always_comb begin
        state_next      = state_reg;
        tmr_next        = tmr_reg;
        open_tmr_next   = open_tmr_reg;
        adv_tmr_next    = adv_tmr_reg;
        adv_cand_next   = adv_cand_reg;
        adv_next        = adv_reg;
        cls_next        = cls_raw;
        stable_cls_next = stable_cls_reg;
        pre_next        = tick ? 14'h0000 : pre_reg + 14'h0001;
        ps_next         = ps_reg;

        // Any change restarts the stability count
        if (cls_raw != cls_reg) begin
            tmr_next      = 12'h000;
            stable_cls_next = cls_raw;
        end else if (tick && tmr_reg != 12'hFFF) begin
            tmr_next = tmr_reg + 12'h001;
        end

        if (stable_cls_reg == CC_OPEN || (!source_mode && stable_cls_reg == CC_POWERED)) begin
            if (tick && open_tmr_reg != 12'hFFF) begin
                open_tmr_next = open_tmr_reg + 12'h001;
            end
        end else begin
            open_tmr_next = 12'h000;
        end
        unique case (state_reg)
            ST_UNATTACHED: begin
                if (recovery_req) begin
                    state_next = ST_RECOVERY;
                    tmr_next   = 12'h000;
                end else if (accessory_seen) begin
                    state_next = ST_ACC_WAIT;
                    tmr_next   = 12'h000;
                end else if (connected) begin
                    state_next = ST_ATTACH_WAIT;
                end
            end
            ST_ATTACH_WAIT: begin
                if (!connected) begin
                    state_next = ST_UNATTACHED;
                end else if (tmr_reg >= att_tc) begin
                    state_next = ST_ATTACHED;
                    adv_next   = adv_raw;
                    adv_cand_next = adv_raw;
                    adv_tmr_next  = 12'h000;
                end
            end
            ST_ATTACHED: begin
                if (recovery_req) begin
                    state_next = ST_RECOVERY;
                    tmr_next   = 12'h000;
                end else if (open_tmr_reg >= det_tc) begin
                    state_next = ST_UNATTACHED;
                end
                // Advertisement must hold before the sink follows it
                if (adv_raw != adv_cand_reg) begin
                    adv_cand_next = adv_raw;
                    adv_tmr_next  = 12'h000;
                end else if (adv_cand_reg != adv_reg) begin
                    if (adv_tmr_reg >= det_tc) begin
                        adv_next = adv_cand_reg;
                    end else if (tick) begin
                        adv_tmr_next = adv_tmr_reg + 12'h001;
                    end
                end else begin
                    adv_tmr_next = 12'h000;
                end
            end
            ST_ACC_WAIT: begin
                if (!accessory_seen) begin
                    state_next = ST_UNATTACHED;
                end else if (tick) begin
                    tmr_next = tmr_reg + 12'h001;
                    if (tmr_reg + 12'h001 >= acc_tc) begin
                        state_next = ST_ACCESSORY;
                    end
                end else begin
                    tmr_next = tmr_reg;
                end
            end
            ST_ACCESSORY: begin
                if (!accessory_seen) begin
                    state_next = ST_UNATTACHED;
                end
            end
            ST_RECOVERY: begin
                tmr_next = tick ? tmr_reg + 12'h001 : tmr_reg;
                if (tmr_reg >= rec_tc) begin
                    state_next = ST_UNATTACHED;
                    tmr_next   = 12'h000;
                end
            end
        endcase
        // Each swap flips its own attribute only
        ps_next.source_role    ^= swap_done.power_swap;
        ps_next.host_role      ^= swap_done.data_swap;
        ps_next.cable_power_on ^= swap_done.cable_power_swap;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg      <= ST_UNATTACHED;
            tmr_reg        <= 12'h000;
            open_tmr_reg   <= 12'h000;
            adv_tmr_reg    <= 12'h000;
            pre_reg        <= 14'h0000;
            cls_reg        <= CC_OPEN;
            stable_cls_reg <= CC_OPEN;
            adv_cand_reg   <= ADV_DEFAULT;
            adv_reg        <= ADV_DEFAULT;
            ps_reg         <= PORT_STATE_RST;
            attached       <= 1'b0;
            accessory_mode <= 1'b0;
            recovery_state <= 1'b0;
            cc_class       <= CC_OPEN;
            partner_adv    <= ADV_DEFAULT;
            port_state     <= PORT_STATE_RST;
        end else if (clk_en) begin
            state_reg      <= state_next;
            tmr_reg        <= tmr_next;
            open_tmr_reg   <= open_tmr_next;
            adv_tmr_reg    <= adv_tmr_next;
            pre_reg        <= pre_next;
            cls_reg        <= cls_next;
            stable_cls_reg <= stable_cls_next;
            adv_cand_reg   <= adv_cand_next;
            adv_reg        <= adv_next;
            ps_reg         <= ps_next;
            attached       <= (state_next == ST_ATTACHED);
            accessory_mode <= (state_next == ST_ACCESSORY);
            recovery_state <= (state_next == ST_RECOVERY);
            cc_class       <= stable_cls_next;
            partner_adv    <= adv_next;
            port_state     <= ps_next;
        end
    end

    a_attach_min: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && state_reg == ST_ATTACH_WAIT && state_next == ST_ATTACHED)
            |-> tmr_reg >= ATTACH_MIN_TK)
        else $error("attach before minimum debounce");
    a_detach_min: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && state_reg == ST_ATTACHED && state_next == ST_UNATTACHED && !recovery_req)
            |-> open_tmr_reg >= DETACH_MIN_TK)
        else $error("detach before minimum debounce");
    a_adv_hold: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && adv_next != adv_reg && state_reg == ST_ATTACHED)
            |-> adv_tmr_reg >= DETACH_MIN_TK)
        else $error("advertisement accepted too early");
    a_acc_window: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && state_reg == ST_ACC_WAIT && state_next == ST_ACCESSORY)
            |-> (tmr_next >= ACC_MIN_TK && tmr_next <= ACC_MAX_TK))
        else $error("accessory entry outside window");
    a_recovery_hold: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && state_reg == ST_RECOVERY && state_next != ST_RECOVERY)
            |-> tmr_reg >= RECOVERY_MIN_TK)
        else $error("recovery left too early");
    a_src_default: assert property (@(posedge core_clk) disable iff (srst)
        (source_mode && own_adv == ADV_DEFAULT && cc_level_mv >= SRC_DEF_RD_MV)
            |-> cls_raw == CC_OPEN)
        else $error("open level misclassified");
    a_src_high: assert property (@(posedge core_clk) disable iff (srst)
        (source_mode && own_adv == ADV_HIGH && cc_level_mv >= SRC_HI_RA_MV
            && cc_level_mv < SRC_HI_RD_MV) |-> cls_raw == CC_SINK)
        else $error("sink level misclassified at high advertisement");
    a_snk_decode: assert property (@(posedge core_clk) disable iff (srst)
        (!source_mode && adv_decode_en && cc_level_mv >= SNK_MID_MV) |-> adv_raw == ADV_HIGH)
        else $error("high advertisement not decoded");
    a_swap_power: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && swap_done == 3'b100) |=> (port_state.source_role != $past(port_state.source_role)
            && port_state.host_role == $past(port_state.host_role)))
        else $error("power swap changed wrong attribute");

endmodule
`default_nettype wire

// ---- design/cc_detect_pkg.sv ----
package cc_detect_pkg;

    // Timebase: one tick every 100 us of core_clk (125 MHz)
    localparam int unsigned CLK_KHZ         = 125000;
    localparam int unsigned TICK_US         = 100;
    localparam int unsigned TICK_CYCLES     = CLK_KHZ * TICK_US / 1000;

    // Intervals in ms as printed; counts are in ticks
    localparam int unsigned ATTACH_MIN_MS   = 2;
    localparam int unsigned ATTACH_MAX_MS   = 15;
    localparam int unsigned DETACH_MIN_MS   = 10;
    localparam int unsigned DETACH_MAX_MS   = 20;
    localparam int unsigned ACC_MIN_MS      = 50;
    localparam int unsigned ACC_MAX_MS      = 200;
    localparam int unsigned RECOVERY_MIN_MS = 25;
    localparam int unsigned TICKS_PER_MS    = 1000 / TICK_US;

    localparam logic [11:0] ATTACH_MIN_TK   = 12'(ATTACH_MIN_MS * TICKS_PER_MS);
    localparam logic [11:0] ATTACH_MAX_TK   = 12'(ATTACH_MAX_MS * TICKS_PER_MS);
    localparam logic [11:0] DETACH_MIN_TK   = 12'(DETACH_MIN_MS * TICKS_PER_MS);
    localparam logic [11:0] DETACH_MAX_TK   = 12'(DETACH_MAX_MS * TICKS_PER_MS);
    localparam logic [11:0] ACC_MIN_TK      = 12'(ACC_MIN_MS * TICKS_PER_MS);
    localparam logic [11:0] ACC_MAX_TK      = 12'(ACC_MAX_MS * TICKS_PER_MS);
    localparam logic [11:0] RECOVERY_MIN_TK = 12'(RECOVERY_MIN_MS * TICKS_PER_MS);

    // CC level digitised in millivolts, thresholds as printed
    localparam logic [11:0] SRC_DEF_RA_MV   = 12'h0C8;  // 0.20 V
    localparam logic [11:0] SRC_DEF_RD_MV   = 12'h640;  // 1.60 V
    localparam logic [11:0] SRC_MID_RA_MV   = 12'h190;  // 0.40 V
    localparam logic [11:0] SRC_MID_RD_MV   = 12'h640;  // 1.60 V
    localparam logic [11:0] SRC_HI_RA_MV    = 12'h320;  // 0.80 V
    localparam logic [11:0] SRC_HI_RD_MV    = 12'hA28;  // 2.60 V
    localparam logic [11:0] SNK_RA_MV       = 12'h0C8;  // 0.2 V
    localparam logic [11:0] SNK_CONNECT_MV  = 12'h0FA;  // 0.25 V
    localparam logic [11:0] SNK_DEF_MV      = 12'h294;  // 0.66 V
    localparam logic [11:0] SNK_MID_MV      = 12'h4CE;  // 1.23 V

    typedef enum logic [1:0] {
        ADV_DEFAULT = 2'h0,
        ADV_MIDDLE  = 2'h1,
        ADV_HIGH    = 2'h2
    } adv_t;

    typedef enum logic [1:0] {
        CC_OPEN     = 2'h0,
        CC_POWERED  = 2'h1,
        CC_SINK     = 2'h2,
        CC_SOURCE   = 2'h3
    } cc_class_t;

    typedef struct packed {
        logic host_role;
        logic source_role;
        logic data_capable;
        logic cable_power_on;
    } port_state_t;

    typedef struct packed {
        logic power_swap;
        logic data_swap;
        logic cable_power_swap;
    } swap_t;

    typedef struct packed {
        logic [11:0] attach_time;
        logic [11:0] detach_time;
        logic [11:0] accessory_time;
        logic [11:0] recovery_time;
    } timing_cfg_t;

    localparam port_state_t PORT_STATE_RST  = '{1'b0, 1'b0, 1'b1, 1'b0};

    function automatic logic [11:0] clamp_count(input logic [11:0] v,
                                               input logic [11:0] lo,
                                               input logic [11:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

endpackage

// ---- testbench/cc_far_port.sv ----
`timescale 1ns/100ps
`default_nettype none
module cc_far_port (
    // Role of the port under test
    input  wire logic        source_mode,
    // Far-end termination as commanded by the bench
    input  wire logic        present,
    input  wire logic [11:0] level_mv,
    input  wire logic        accessory,
    // Towards the port under test
    output logic [11:0]      cc_level_mv,
    output logic             accessory_seen
);
    // With the cable pulled the line rests at the port's own termination:
    // pulled above the open level by a source, pulled to ground by a sink.
    // The bench models this as a fixed level rather than a held last value.
    assign cc_level_mv    = present ? level_mv : (source_mode ? 12'hBB8 : 12'h000);
    assign accessory_seen = present & accessory;
endmodule
`default_nettype wire

// ---- testbench/tb_cc_attach_detect_debounce.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_cc_attach_detect_debounce;
    import cc_detect_pkg::*;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        clk_en = 1'b1;
    logic        source_mode = 1'b0;
    adv_t        own_adv = ADV_DEFAULT;
    logic        adv_decode_en = 1'b0;
    timing_cfg_t timing_cfg = '0;
    logic        recovery_req = 1'b0;
    swap_t       swap_done = '0;
    logic        present = 1'b0;
    logic [11:0] level_mv = 12'h000;
    logic        accessory = 1'b0;
    logic [11:0] cc_level_mv;
    logic        accessory_seen;
    logic        attached;
    logic        accessory_mode;
    logic        recovery_state;
    cc_class_t   cc_class;
    adv_t        partner_adv;
    port_state_t port_state;
    int          fails = 0;
    int          checked = 0;
    logic [11:0] ra_tab [3] = '{12'h0C8, 12'h190, 12'h320};
    logic [11:0] rd_tab [3] = '{12'h640, 12'h640, 12'hA28};

    // Short tick so that the millisecond windows fit a brief run
    localparam int TB_TICK = 10;

    always #4 core_clk = ~core_clk;

    cc_far_port far (
        .source_mode    (source_mode),
        .present        (present),
        .level_mv       (level_mv),
        .accessory      (accessory),
        .cc_level_mv    (cc_level_mv),
        .accessory_seen (accessory_seen)
    );

    cc_attach_detect_debounce #(.TICK_DIV(TB_TICK)) uut (
        .core_clk       (core_clk),
        .srst           (srst),
        .clk_en         (clk_en),
        .cc_level_mv    (cc_level_mv),
        .source_mode    (source_mode),
        .own_adv        (own_adv),
        .adv_decode_en  (adv_decode_en),
        .accessory_seen (accessory_seen),
        .timing_cfg     (timing_cfg),
        .recovery_req   (recovery_req),
        .swap_done      (swap_done),
        .attached       (attached),
        .accessory_mode (accessory_mode),
        .recovery_state (recovery_state),
        .cc_class       (cc_class),
        .partner_adv    (partner_adv),
        .port_state     (port_state)
    );

    task automatic tally_and_finish();
        $display("checks made %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic do_reset();
        @(negedge core_clk);
        srst = 1'b1;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
    endtask

    // Level applied at a falling edge is classified at the next rising edge
    task automatic apply_level(input logic [11:0] lv, input cc_class_t exp);
        @(negedge core_clk);
        present = 1'b1;
        level_mv = lv;
        @(negedge core_clk);
        check("cc_class", 12'(cc_class), 12'(exp));
    endtask

    task automatic pulse_swap(input swap_t s, input logic [3:0] exp);
        @(negedge core_clk);
        swap_done = s;
        @(negedge core_clk);
        swap_done = '0;
        check("port_state", 12'(port_state), 12'(exp));
    endtask

    task automatic wait_ticks(input int n);
        repeat (n * TB_TICK) @(negedge core_clk);
    endtask

    function automatic logic [11:0] probe(input int sel);
        case (sel)
            0:       return 12'(attached);
            1:       return 12'(accessory_mode);
            2:       return 12'(recovery_state);
            default: return 12'(partner_adv);
        endcase
    endfunction

    // Waits a bounded number of ticks; running out is a mismatch and ends the run
    task automatic wait_for(input string what, input int sel, input logic [11:0] exp,
                            input int ticks);
        int n;
        n = 0;
        while (probe(sel) !== exp && n < ticks * TB_TICK) begin
            @(negedge core_clk);
            n++;
        end
        check(what, probe(sel), exp);
        if (probe(sel) !== exp) begin
            tally_and_finish();
        end
    endtask

    initial begin
        int n;
        do_reset();
        @(negedge core_clk);
        check("port_state", 12'(port_state), 12'h002);
        check("attached", 12'(attached), 12'h000);
        check("recovery_state", 12'(recovery_state), 12'h000);
        // Source role, every advertisement, just below and at each threshold
        source_mode = 1'b1;
        for (int a = 0; a < 3; a++) begin
            own_adv = adv_t'(a);
            apply_level(ra_tab[a] - 12'h001, CC_POWERED);
            apply_level(ra_tab[a], CC_SINK);
            apply_level(rd_tab[a] - 12'h001, CC_SINK);
            apply_level(rd_tab[a], CC_OPEN);
        end
        // Sink role without decoding; the gap between levels keeps the class
        source_mode = 1'b0;
        apply_level(12'h0C7, CC_POWERED);
        apply_level(12'h0DC, CC_POWERED);
        apply_level(12'h0FA, CC_SOURCE);
        apply_level(12'h0DC, CC_SOURCE);
        // Role swaps, one at a time, then all together
        pulse_swap('{1'b1, 1'b0, 1'b0}, 4'h6);
        pulse_swap('{1'b0, 1'b1, 1'b0}, 4'hE);
        pulse_swap('{1'b0, 1'b0, 1'b1}, 4'hF);
        pulse_swap('{1'b1, 1'b1, 1'b1}, 4'h2);
        // A frozen block ignores a swap pulse
        clk_en = 1'b0;
        pulse_swap('{1'b1, 1'b0, 1'b0}, 4'h2);
        clk_en = 1'b1;
        // Pull the cable so the port is unattached, then request recovery
        @(negedge core_clk);
        present = 1'b0;
        repeat (2) @(negedge core_clk);
        recovery_req = 1'b1;
        @(negedge core_clk);
        recovery_req = 1'b0;
        check("recovery_state", 12'(recovery_state), 12'h001);
        wait_ticks(5);
        check("recovery_state", 12'(recovery_state), 12'h001);
        wait_ticks(240);
        check("recovery_state", 12'(recovery_state), 12'h001);
        wait_for("recovery exit", 2, 12'h000, 20);
        // Mid-run reset, then the accessory condition held through its window
        do_reset();
        @(negedge core_clk);
        present = 1'b1;
        accessory = 1'b1;
        wait_ticks(10);
        check("accessory_mode", 12'(accessory_mode), 12'h000);
        wait_ticks(480);
        check("accessory_mode", 12'(accessory_mode), 12'h000);
        wait_for("accessory entry", 1, 12'h001, 20);
        accessory = 1'b0;
        @(negedge core_clk);
        check("accessory_mode", 12'(accessory_mode), 12'h000);
        // Decoding sink attach; zero counts are lifted to the legal minimum
        do_reset();
        adv_decode_en = 1'b1;
        apply_level(12'h1F4, CC_SOURCE);
        wait_ticks(19);
        check("attached", 12'(attached), 12'h000);
        n = 0;
        while (attached !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 3 * TB_TICK) begin
                check("attach wait", 12'h000, 12'h001);
                tally_and_finish();
            end
        end
        check("attached", 12'(attached), 12'h001);
        check("partner_adv", 12'(partner_adv), 12'(ADV_DEFAULT));
        // Advertisement change is taken only once it has persisted
        @(negedge core_clk);
        level_mv = 12'h5DC;
        wait_ticks(10);
        check("partner_adv", 12'(partner_adv), 12'(ADV_DEFAULT));
        wait_ticks(85);
        check("partner_adv", 12'(partner_adv), 12'(ADV_DEFAULT));
        wait_for("partner_adv", 3, 12'(ADV_HIGH), 20);
        // Cable pulled: detach only after its own longer debounce
        @(negedge core_clk);
        present = 1'b0;
        wait_ticks(10);
        check("attached", 12'(attached), 12'h001);
        wait_ticks(85);
        check("attached", 12'(attached), 12'h001);
        wait_for("detach", 0, 12'h000, 20);
        tally_and_finish();
    end
endmodule
`default_nettype wire
